/* File: rtl/cpgw_top.sv */
// Configuration port with eight-pin group and watchdog timer registers.
`timescale 1ns/10ps
`default_nettype none
module cpgw_top
  import cpgw_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = UNIT_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        base_alt,
  input  wire logic [7:0]  gp_in,
  output var  logic [7:0]  io_rdata,
  output var  logic        io_rvalid,
  output var  logic [7:0]  gp_out,
  output var  logic [7:0]  gp_oe,
  output var  logic        wdt_cpu_rst,
  output var  logic        wdt_irq
);
  // ****************************************
  // Declarations.
  // ****************************************
  cpgw_pin_if  pin_bus ();
  cpgw_state_t st_r, st_nxt;
  logic [7:0]  idx_r, idx_nxt;
  logic [7:0]  ldn_r, ldn_nxt;
  logic        act_r, act_nxt;
  logic [7:0]  unit_r, unit_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic        mode_r, mode_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic        crst_r, crst_nxt;
  logic        irq_r, irq_nxt;
  logic        alt_s1_r;
  logic        alt_s2_r;
  logic        idx_hit;
  logic        dat_hit;
  logic        idx_wr;
  logic        dat_wr;
  logic        dat_rd;
  logic        tick;
  logic        expiry;
  logic [7:0]  rd_val;

  // Matches an address against the primary or alternative port.
  function automatic logic port_hit(input logic [15:0] addr,
                                    input logic [15:0] pri,
                                    input logic [15:0] alt,
                                    input logic        use_alt);
    port_hit = (addr == (use_alt ? alt : pri));
  endfunction

  // True when a data access reaches the given device and index.
  function automatic logic reg_is(input logic [7:0] ldn,
                                  input logic [7:0] idx,
                                  input logic [7:0] want_ldn,
                                  input logic [7:0] want_idx);
    reg_is = (ldn == want_ldn) && (idx == want_idx);
  endfunction

  // ****************************************
  // Port decode.
  // ****************************************
  // Base select strap comes from a pin, so it is synchronised first.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_s1_r <= 1'b0;
      alt_s2_r <= 1'b0;
    end else begin
      alt_s1_r <= base_alt;
      alt_s2_r <= alt_s1_r;
    end
  end

  // Index and data ports sit at paired addresses; data needs an open port.
  assign idx_hit = port_hit(io_addr, IDX_PORT_A, IDX_PORT_B, alt_s2_r);  // see RL5
  assign dat_hit = port_hit(io_addr, DAT_PORT_A, DAT_PORT_B, alt_s2_r);  // see RL6
  assign idx_wr  = io_wr && idx_hit;
  assign dat_wr  = io_wr && dat_hit && (st_r == ST_OPEN);  // see RL8
  assign dat_rd  = io_rd && dat_hit && (st_r == ST_OPEN);  // see RL8

  // ****************************************
  // Entry and exit sequence.
  // ****************************************
  // Next state and index from index port writes.
  always_comb begin
    st_nxt  = st_r;
    idx_nxt = idx_r;
    unique case (st_r)
      ST_LOCK: begin
        if (idx_wr && io_wdata == KEY_ENTER) begin
          st_nxt = ST_KEY1;
        end
      end
      ST_KEY1: begin
        if (idx_wr) begin
          st_nxt = (io_wdata == KEY_ENTER) ? ST_OPEN : ST_LOCK;  // see RL7
        end
      end
      ST_OPEN: begin
        if (idx_wr && io_wdata == KEY_EXIT) begin
          st_nxt = ST_LOCK;  // see RL8
        end else if (idx_wr) begin
          idx_nxt = io_wdata;  // see RL15
        end
      end
      default: begin
        st_nxt = ST_LOCK;
      end
    endcase
  end

  // Register the port state.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r  <= ST_LOCK;
      idx_r <= IDX_RST;
    end else begin
      st_r  <= st_nxt;
      idx_r <= idx_nxt;
    end
  end

  // ****************************************
  // Logical device and watchdog registers.
  // ****************************************
  // Data port writes land in the register chosen by device and index.
  always_comb begin
    ldn_nxt  = ldn_r;
    act_nxt  = act_r;
    unit_nxt = unit_r;
    mode_nxt = mode_r;
    if (dat_wr && idx_r == IDX_LDN) begin
      ldn_nxt = io_wdata;  // see RL9
    end
    if (dat_wr && reg_is(ldn_r, idx_r, LDN_WDT, IDX_WDT_ACT)) begin
      act_nxt = io_wdata[0];  // see RL11 see RL12
    end
    if (dat_wr && reg_is(ldn_r, idx_r, LDN_WDT, IDX_WDT_UNIT)) begin
      unit_nxt = io_wdata;  // see RL13
    end
    if (dat_wr && reg_is(ldn_r, idx_r, LDN_WDT, IDX_WDT_MODE)) begin
      mode_nxt = io_wdata[0];
    end
  end

  // Pin group strobes for logical device 7.
  assign pin_bus.dir_wr = dat_wr && reg_is(ldn_r, idx_r, LDN_GPIO, IDX_DIR);  // see RL10
  assign pin_bus.dat_wr = dat_wr && reg_is(ldn_r, idx_r, LDN_GPIO, IDX_DAT);  // see RL10
  assign pin_bus.pol_wr = dat_wr && reg_is(ldn_r, idx_r, LDN_GPIO, IDX_POL);  // see RL10
  assign pin_bus.wdata  = io_wdata;

  // ****************************************
  // Watchdog counter.
  // ****************************************
  // A count write reloads; each unit tick of an active watchdog counts down until the count reaches zero, where it holds.
  always_comb begin
    expiry   = act_r && tick && (cnt_r == 8'h01);
    cnt_nxt  = cnt_r;
    crst_nxt = expiry && !mode_r;  // see RL14
    irq_nxt  = expiry && mode_r;   // see RL14
    if (dat_wr && reg_is(ldn_r, idx_r, LDN_WDT, IDX_WDT_CNT)) begin
      cnt_nxt = io_wdata;
    end else if (act_r && tick && cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'h01;
    end
  end

  // Counting unit divider; unit 00h selects seconds.
  cpgw_unit_tick #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (act_r),
    .minutes (unit_r[UNIT_MIN_BIT]),  // see RL13
    .tick    (tick)
  );

  // Register the device and watchdog state.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ldn_r  <= LDN_RST;
      act_r  <= 1'b0;
      unit_r <= UNIT_RST;
      mode_r <= 1'b0;
      cnt_r  <= CNT_RST;
      crst_r <= 1'b0;
      irq_r  <= 1'b0;
    end else begin
      ldn_r  <= ldn_nxt;
      act_r  <= act_nxt;
      unit_r <= unit_nxt;
      mode_r <= mode_nxt;
      cnt_r  <= cnt_nxt;
      crst_r <= crst_nxt;
      irq_r  <= irq_nxt;
    end
  end

  // ****************************************
  // Pin group.
  // ****************************************
  cpgw_pin_group u_pins (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cfg     (pin_bus),
    .gp_in   (gp_in),
    .gp_out  (gp_out),
    .gp_oe   (gp_oe)
  );

  // ****************************************
  // Read path.
  // ****************************************
  // Select the read value from the current device and index.
  always_comb begin
    rd_val = 8'h00;
    if (idx_r == IDX_LDN) begin
      rd_val = ldn_r;
    end else if (ldn_r == LDN_GPIO) begin
      unique case (idx_r)  // see RL15
        IDX_DIR: rd_val = pin_bus.dir_val;
        IDX_DAT: rd_val = pin_bus.dat_val;  // see RL2
        IDX_POL: rd_val = pin_bus.pol_val;
        default: rd_val = 8'h00;
      endcase
    end else if (ldn_r == LDN_WDT) begin
      unique case (idx_r)
        IDX_WDT_ACT:  rd_val = {7'h00, act_r};
        IDX_WDT_UNIT: rd_val = unit_r;
        IDX_WDT_CNT:  rd_val = cnt_r;
        IDX_WDT_MODE: rd_val = {7'h00, mode_r};
        default:      rd_val = 8'h00;
      endcase
    end
  end

  // Reads of the index port return a fixed value; closed data reads are ignored.
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    if (io_rd && idx_hit) begin
      rdata_nxt  = IDX_PORT_RD;  // see RL5
      rvalid_nxt = 1'b1;
    end else if (dat_rd) begin
      rdata_nxt  = rd_val;
      rvalid_nxt = 1'b1;
    end
  end

  // Register the read answer.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign io_rdata    = rdata_r;
  assign io_rvalid   = rvalid_r;
  assign wdt_cpu_rst = crst_r;
  assign wdt_irq     = irq_r;

  // ****************************************
  // Checks.
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_open_after_two: assert property (  // see RL7
    st_r == ST_OPEN && $past(st_r) != ST_OPEN |-> $past(st_r) == ST_KEY1 && $past(io_wdata) == KEY_ENTER)
    else $error("Configuration opened without two entry keys.");
  a_exit_closes: assert property (  // see RL8
    st_r == ST_OPEN && idx_wr && io_wdata == KEY_EXIT |=> st_r == ST_LOCK ##1 !pin_bus.dat_wr)
    else $error("Exit key did not close the port.");
  a_locked_ignores: assert property (  // see RL8
    st_r != ST_OPEN && io_wr && dat_hit |=> $stable(ldn_r) && $stable(act_r))
    else $error("Data write took effect while closed.");
  a_ldn_select: assert property (  // see RL9
    dat_wr && idx_r == IDX_LDN |=> ldn_r == $past(io_wdata))
    else $error("Logical device number not stored.");
  a_read_answer: assert property (  // see RL15
    dat_rd |=> io_rvalid && io_rdata == $past(rd_val))
    else $error("Data read answer wrong.");
  a_index_wo: assert property (  // see RL5
    io_rd && idx_hit |=> io_rvalid && io_rdata == IDX_PORT_RD)
    else $error("Index port read returned state.");
  a_wdt_activate: assert property (  // see RL12
    dat_wr && reg_is(ldn_r, idx_r, LDN_WDT, IDX_WDT_ACT) |=> act_r == $past(io_wdata[0]))
    else $error("Watchdog activation not stored.");
  a_expiry_action: assert property (  // see RL14
    expiry |=> (wdt_cpu_rst != wdt_irq) && (wdt_irq == $past(mode_r)) ##1 !wdt_cpu_rst && !wdt_irq)
    else $error("Watchdog expiry action wrong.");
  a_gpio_strobe: assert property (  // see RL10
    pin_bus.dat_wr |-> ldn_r == LDN_GPIO && idx_r == IDX_DAT && st_r == ST_OPEN)
    else $error("Pin data strobe outside device 7.");

  c_enter_open: cover property (st_r == ST_KEY1 ##1 st_r == ST_OPEN);
  c_pin_write:  cover property (pin_bus.dat_wr);
  c_wdt_expiry: cover property (expiry ##1 wdt_cpu_rst);
  c_exit:       cover property (st_r == ST_OPEN ##1 st_r == ST_LOCK);
endmodule
`default_nettype wire

/* File: shared/cpgw_pkg.sv */
// Constants shared by the configuration port, pin group and watchdog timer.
// Notes on behaviour
// RL1 - Direction bit 1 makes a pin an input, 0 an output; resets to all ones.
// RL2 - Data bits of output pins are host writable and readable; data resets to zero.
// RL3 - Data bits of input pins are read only; host writes leave them unchanged.
// RL4 - Polarity bit 1 inverts pin values both ways; 0 passes them; resets to zero.
// RL5 - Index port is write only, decoded at 2Eh or alternatively 4Eh.
// RL6 - Data port is read/write, decoded at 2Fh or 4Fh, paired with index port.
// RL7 - Two successive index writes of 87h open configuration mode.
// RL8 - Index write of AAh closes configuration mode; data accesses are then ignored.
// RL9 - Index 07h holds the logical device number selecting the later registers.
// RL10 - Logical device 7 holds direction F0h, pin data F1h and polarity F2h.
// RL11 - Logical device 8 holds the watchdog registers.
// RL12 - Watchdog index 30h: writing 01h activates, 00h deactivates the watchdog.
// RL13 - Watchdog index F5h selects counting unit; 00h means one second.
// RL14 - On expiry the active watchdog resets the processor or raises an interrupt.
// RL15 - Last index written picks the register that data port accesses reach.
// RL16 - Output pin drives data XOR polarity; input read returns pin XOR polarity.
package cpgw_pkg;
  // ****************************************
  // Host ports and keys.
  // ****************************************
  localparam logic [15:0] IDX_PORT_A   = 16'h002e;
  localparam logic [15:0] IDX_PORT_B   = 16'h004e;
  localparam logic [15:0] DAT_PORT_A   = 16'h002f;
  localparam logic [15:0] DAT_PORT_B   = 16'h004f;
  localparam logic [7:0]  KEY_ENTER    = 8'h87;
  localparam logic [7:0]  KEY_EXIT     = 8'haa;
  localparam logic [7:0]  IDX_PORT_RD  = 8'h00;
  // ****************************************
  // Register indices and logical devices.
  // ****************************************
  localparam logic [7:0]  IDX_LDN      = 8'h07;
  localparam logic [7:0]  LDN_GPIO     = 8'h07;
  localparam logic [7:0]  LDN_WDT      = 8'h08;
  localparam logic [7:0]  IDX_DIR      = 8'hf0;
  localparam logic [7:0]  IDX_DAT      = 8'hf1;
  localparam logic [7:0]  IDX_POL      = 8'hf2;
  localparam logic [7:0]  IDX_WDT_ACT  = 8'h30;
  localparam logic [7:0]  IDX_WDT_UNIT = 8'hf5;
  localparam logic [7:0]  IDX_WDT_CNT  = 8'hf6;
  localparam logic [7:0]  IDX_WDT_MODE = 8'hf7;
  localparam int          UNIT_MIN_BIT = 3;
  // ****************************************
  // Reset values.
  // ****************************************
  localparam logic [7:0]  DIR_RST      = 8'hff;
  localparam logic [7:0]  DAT_RST      = 8'h00;
  localparam logic [7:0]  POL_RST      = 8'h00;
  localparam logic [7:0]  LDN_RST      = 8'h00;
  localparam logic [7:0]  IDX_RST      = 8'h00;
  localparam logic [7:0]  UNIT_RST     = 8'h00;
  localparam logic [7:0]  CNT_RST      = 8'h00;
  // ****************************************
  // Timing.
  // ****************************************
  localparam longint      CLK_HZ       = 100_000_000;
  localparam longint      UNIT_TIME_S  = 1;
  localparam int unsigned UNIT_CYCLES  = 32'(UNIT_TIME_S * CLK_HZ);
  localparam logic [5:0]  SEC_PER_MIN  = 6'h3c;
  // ****************************************
  // Configuration port states.
  // ****************************************
  typedef enum logic [2:0] {
    ST_LOCK = 3'b001,
    ST_KEY1 = 3'b010,
    ST_OPEN = 3'b100
  } cpgw_state_t;
endpackage

/* File: shared/cpgw_pin_if.sv */
// Interface between the configuration decoder and the pin group registers.
`timescale 1ns/10ps
`default_nettype none
interface cpgw_pin_if;
  logic       dir_wr;
  logic       dat_wr;
  logic       pol_wr;
  logic [7:0] wdata;
  logic [7:0] dir_val;
  logic [7:0] dat_val;
  logic [7:0] pol_val;
  modport ctrl (output dir_wr, dat_wr, pol_wr, wdata, input dir_val, dat_val, pol_val);
  modport pins (input dir_wr, dat_wr, pol_wr, wdata, output dir_val, dat_val, pol_val);
endinterface
`default_nettype wire

/* File: rtl/cpgw_unit_tick.sv */
// Watchdog counting unit divider giving one-cycle second or minute pulses.
`timescale 1ns/10ps
`default_nettype none
module cpgw_unit_tick
  import cpgw_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = UNIT_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic minutes,
  output var  logic tick
);
  logic [31:0] div_r;
  logic [31:0] div_nxt;
  logic [5:0]  sec_r;
  logic [5:0]  sec_nxt;
  logic        tick_r;
  logic        tick_nxt;
  logic        sec_end;

  // Count cycles into seconds, then seconds into minutes when asked.
  always_comb begin
    sec_end  = run && (div_r == 32'(SEC_CYCLES - 1));
    div_nxt  = (!run || sec_end) ? 32'h0 : div_r + 32'h1;
    sec_nxt  = sec_r;
    tick_nxt = 1'b0;
    if (!run) begin
      sec_nxt = 6'h0;
    end else if (sec_end) begin
      if (!minutes) begin
        tick_nxt = 1'b1;
        sec_nxt  = 6'h0;
      end else if (sec_r == SEC_PER_MIN - 6'h1) begin
        tick_nxt = 1'b1;
        sec_nxt  = 6'h0;
      end else begin
        sec_nxt = sec_r + 6'h1;
      end
    end
  end

  // Register the divider state.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r  <= 32'h0;
      sec_r  <= 6'h0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      sec_r  <= sec_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule
`default_nettype wire

/* File: rtl/cpgw_pin_group.sv */
// Eight-pin group with direction, data and polarity registers.
`timescale 1ns/10ps
`default_nettype none
module cpgw_pin_group
  import cpgw_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  cpgw_pin_if.pins        cfg,
  input  wire logic [7:0] gp_in,
  output var  logic [7:0] gp_out,
  output var  logic [7:0] gp_oe
);
  logic [7:0] dir_r, dir_nxt;
  logic [7:0] dat_r, dat_nxt;
  logic [7:0] pol_r, pol_nxt;
  logic [7:0] in_s1_r;
  logic [7:0] in_s2_r;
  logic [7:0] out_r;
  logic [7:0] oe_r;

  // Compute next register values from host writes.
  always_comb begin
    dir_nxt = cfg.dir_wr ? cfg.wdata : dir_r;  // see RL1
    pol_nxt = cfg.pol_wr ? cfg.wdata : pol_r;  // see RL4
    dat_nxt = dat_r;
    if (cfg.dat_wr) begin
      dat_nxt = (cfg.wdata & ~dir_r) | (dat_r & dir_r);  // see RL2 see RL3
    end
  end

  // Register state, synchronise the pins and drive them.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_r   <= DIR_RST;
      dat_r   <= DAT_RST;
      pol_r   <= POL_RST;
      in_s1_r <= 8'h00;
      in_s2_r <= 8'h00;
      out_r   <= 8'h00;
      oe_r    <= 8'h00;
    end else begin
      dir_r   <= dir_nxt;
      dat_r   <= dat_nxt;
      pol_r   <= pol_nxt;
      in_s1_r <= gp_in;
      in_s2_r <= in_s1_r;
      out_r   <= dat_r ^ pol_r;  // see RL16 see RL4
      oe_r    <= ~dir_r;         // see RL1
    end
  end

  // Output bits read back as written, input bits as the inverted-if-asked pin.
  assign cfg.dat_val = (dat_r & ~dir_r) | ((in_s2_r ^ pol_r) & dir_r);  // see RL16
  assign cfg.dir_val = dir_r;
  assign cfg.pol_val = pol_r;
  assign gp_out      = out_r;
  assign gp_oe       = oe_r;

  // ****************************************
  // Checks.
  // ****************************************
  a_input_bits_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)  // see RL3
    cfg.dat_wr |=> ((dat_r ^ $past(dat_r)) & $past(dir_r)) == 8'h00)
    else $error("Input data bit changed by a host write.");
  a_dir_to_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)  // see RL1
    cfg.dir_wr ##1 !cfg.dir_wr |=> gp_oe == ~$past(cfg.wdata, 2))
    else $error("Pin enable does not follow direction write.");
  // Only the bits that were outputs at the write must show the written value.
  a_pin_drive_xor: assert property (@(posedge sys_clk) disable iff (!rst_n)  // see RL16
    cfg.dat_wr && !cfg.pol_wr ##1 !cfg.pol_wr && !cfg.dat_wr
    |=> ((gp_out ^ $past(cfg.wdata, 2) ^ pol_r) & ~$past(dir_r, 2)) == 8'h00)
    else $error("Output pin does not show data XOR polarity.");
endmodule
`default_nettype wire

/* File: testbench/cpgw_pin_model.sv */
// Behavioural model of the external circuits on the eight general pins.
`timescale 1ns/10ps
`default_nettype none
module cpgw_pin_model
  import cpgw_pkg::*;
(
  input  wire logic [7:0] gp_out,
  input  wire logic [7:0] gp_oe,
  input  wire logic [7:0] ext_val,
  output var  logic [7:0] gp_in
);
  // ****************************************
  // Pin levels.
  // ****************************************
  // Pins that the device drives show its level, and the outside circuit drives the rest.
  always_comb begin
    gp_in = (gp_oe & gp_out) | (~gp_oe & ext_val);
  end
endmodule
`default_nettype wire

/* File: testbench/cpgw_top_test.sv */
// Self-checking testbench for the configuration port with pin group and watchdog.
`timescale 1ns/10ps
`default_nettype none
module cpgw_top_test
  import cpgw_pkg::*;
;
  // ****************************************
  // Signals and instances.
  // ****************************************
  localparam int unsigned SEC_SIM = 20;
  logic        sys_clk, rst_n, io_wr, io_rd, base_alt, io_rvalid, wdt_cpu_rst, wdt_irq, rd_ok;
  logic [15:0] io_addr, idx_p, dat_p;
  logic [7:0]  io_wdata, gp_in, io_rdata, gp_out, gp_oe, ext_val, rd_v;
  int          n_errors = 0;
  int          comparisons = 0;
  int          n_rst = 0;
  int          n_irq = 0;

  cpgw_top #(.SEC_CYCLES(SEC_SIM)) i_cpgw_top (
    .sys_clk(sys_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .base_alt(base_alt), .gp_in(gp_in), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .gp_out(gp_out), .gp_oe(gp_oe), .wdt_cpu_rst(wdt_cpu_rst),
    .wdt_irq(wdt_irq));

  cpgw_pin_model i_cpgw_pin_model (.gp_out(gp_out), .gp_oe(gp_oe), .ext_val(ext_val), .gp_in(gp_in));

  // The clock toggles every half period of 5 ns.
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  // Expiry pulses are counted so that later checks see every one of them.
  always @(posedge sys_clk) begin
    if (wdt_cpu_rst === 1'b1) n_rst++;
    if (wdt_irq === 1'b1) n_irq++;
  end

  // ****************************************
  // Tasks.
  // ****************************************
  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compares one byte against its expected value.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe on the host port.
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    io_wr = 1'b0;
  endtask

  // One-cycle read strobe; the answer pulse stands in the cycle after the strobe.
  task automatic bus_rd(input logic [15:0] a);
    @(posedge sys_clk);
    #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    io_rd = 1'b0;
    rd_ok = io_rvalid;
    rd_v = io_rdata;
  endtask

  // Writes a configuration register through the index and data ports.
  task automatic cfg_wr(input logic [7:0] i, input logic [7:0] v);
    bus_wr(idx_p, i);
    bus_wr(dat_p, v);
  endtask

  // Reads a configuration register and checks both the answer and its value.
  task automatic cfg_chk(input logic [7:0] i, input logic [7:0] exp);
    bus_wr(idx_p, i);
    bus_rd(dat_p);
    chk({7'h00, rd_ok}, 8'h01);
    chk(rd_v, exp);
  endtask

  // Waits a bounded time for the expiry counts, then checks both of them.
  task automatic wait_wdt(input int want_rst, input int want_irq);
    int k;
    k = 0;
    while (k < 300 && !(n_rst >= want_rst && n_irq >= want_irq)) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 300) begin
      n_errors++;
      $display("[FAIL] %0t watchdog wait timed out", $time);
      complete_run();
    end else begin
      chk(8'(n_rst), 8'(want_rst));
      chk(8'(n_irq), 8'(want_irq));
    end
  endtask

  // ****************************************
  // Main sequence.
  // ****************************************
  // A hang is cut short and reported as a failure.
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end

  // Works through lock, pin group, base selection and watchdog settings in turn.
  initial begin
    rst_n = 1'b0;
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
    base_alt = 1'b0;
    ext_val = 8'h96;
    idx_p = IDX_PORT_A;
    dat_p = DAT_PORT_A;
    repeat (8) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    chk(gp_oe, 8'h00);
    chk(gp_out, 8'h00);
    bus_rd(idx_p);
    chk({7'h00, rd_ok}, 8'h01);
    chk(rd_v, IDX_PORT_RD);
    bus_rd(dat_p);
    chk({7'h00, rd_ok}, 8'h00);
    bus_rd(16'h0060);
    chk({7'h00, rd_ok}, 8'h00);
    // An index write between the two keys cancels the entry.
    bus_wr(idx_p, KEY_ENTER);
    bus_wr(idx_p, IDX_LDN);
    bus_wr(idx_p, KEY_ENTER);
    bus_rd(dat_p);
    chk({7'h00, rd_ok}, 8'h00);
    bus_wr(idx_p, KEY_ENTER);
    cfg_wr(IDX_LDN, LDN_GPIO);
    cfg_chk(IDX_DIR, 8'hff);
    cfg_chk(IDX_POL, 8'h00);
    cfg_chk(IDX_DAT, 8'h96);
    // Low nibble becomes output (direction bit 0); writes to the input nibble must not land.
    cfg_wr(IDX_DIR, 8'hf0);
    cfg_wr(IDX_DAT, 8'ha5);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(gp_oe, 8'h0f);
    chk(gp_out, 8'h05);
    cfg_chk(IDX_DAT, 8'h95);
    cfg_wr(IDX_POL, 8'h3c);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(gp_out, 8'h39);
    // Input nibble reads the outside level 9h inverted by polarity 3h.
    cfg_chk(IDX_DAT, 8'ha5);
    cfg_chk(IDX_POL, 8'h3c);
    // After the exit key, data port traffic is ignored.
    bus_wr(idx_p, KEY_EXIT);
    bus_wr(dat_p, 8'h00);
    bus_rd(dat_p);
    chk({7'h00, rd_ok}, 8'h00);
    chk(gp_out, 8'h39);
    bus_wr(idx_p, KEY_ENTER);
    bus_wr(idx_p, KEY_ENTER);
    cfg_chk(IDX_DAT, 8'ha5);
    cfg_chk(IDX_DIR, 8'hf0);
    // The alternate base takes over and the first data port stops decoding.
    base_alt = 1'b1;
    idx_p = IDX_PORT_B;
    dat_p = DAT_PORT_B;
    repeat (3) @(posedge sys_clk);
    bus_rd(DAT_PORT_A);
    chk({7'h00, rd_ok}, 8'h00);
    cfg_chk(IDX_POL, 8'h3c);
    // Watchdog in reset mode, then interrupt mode, then inactive.
    cfg_wr(IDX_LDN, LDN_WDT);
    cfg_chk(IDX_LDN, LDN_WDT);
    cfg_wr(IDX_WDT_UNIT, 8'h00);
    cfg_chk(IDX_WDT_UNIT, 8'h00);
    cfg_wr(IDX_WDT_MODE, 8'h00);
    cfg_wr(IDX_WDT_CNT, 8'h02);
    cfg_wr(IDX_WDT_ACT, 8'h01);
    cfg_chk(IDX_WDT_ACT, 8'h01);
    wait_wdt(1, 0);
    cfg_wr(IDX_WDT_MODE, 8'h01);
    cfg_wr(IDX_WDT_CNT, 8'h01);
    wait_wdt(1, 1);
    cfg_wr(IDX_WDT_ACT, 8'h00);
    cfg_wr(IDX_WDT_CNT, 8'h01);
    repeat (100) @(posedge sys_clk);
    cfg_chk(IDX_WDT_CNT, 8'h01);
    chk(8'(n_rst + n_irq), 8'h02);
    // Minute unit: no expiry after 55 seconds, one after sixty of them.
    cfg_wr(IDX_WDT_UNIT, 8'h08);
    cfg_wr(IDX_WDT_ACT, 8'h01);
    repeat (1100) @(posedge sys_clk);
    chk(8'(n_irq), 8'h01);
    wait_wdt(1, 2);
    complete_run();
  end
endmodule
`default_nettype wire
